// >>> hw/gpio_pad_function_mux.v
// Contract
// - After reset every pad is a general-purpose input with open-drain driver.
// - Driver-type bit per pad picks push-pull when set, open-drain when clear.
// - Two-wire clock and data pads are always open-drain.
// - Serial receive pad always open-drain; serial transmit follows driver-type bit.
// - SPI route bit 0 enables SPI pads, removing their general-purpose function.
// - SPI set bit picks pads 0-3 or 9-12 for CS, MOSI, MISO, SCLK.
// - SPI output lines follow driver-type bits of their pads.
// - Serial route bit 0 enables serial pads, removing general-purpose function.
// - Serial set bits place TX/RX on 4/8, 2/3, 6/7 or 9/10.
// - Two-wire route bit 0 enables its pads, removing general-purpose function.
// - Two-wire set bits place clock/data on 11/12, 0/1, 4/5 or 14/15.
// - Bypass drives companion transmit from pad 4 and shows receive on pad 2.
// - One source per pad: bypass, two-wire, serial, SPI, then general-purpose.
// - Unclaimed pads, including the unselected set, stay general-purpose.
`timescale 1ns/100ps
`include "pad_mux_consts.vh"

module gpio_pad_function_mux (
  input  wire        clk_i,
  input  wire        rstn_i,
  // Static configuration
  input  wire [15:0] pad_driver_type_i,
  input  wire [1:0]  spi_route_cfg_i,
  input  wire [2:0]  serial_port_route_cfg_i,
  input  wire [2:0]  twowire_route_cfg_i,
  input  wire        bus_phy_test_bypass_i,
  // Pads
  input  wire [15:0] pad_in_i,
  output wire [15:0] pad_out_o,
  output wire [15:0] pad_oe_o,
  // General-purpose pad module
  input  wire [15:0] gpio_out_i,
  input  wire [15:0] gpio_oe_i,
  output reg  [15:0] gpio_in_o,
  // Secondary SPI
  input  wire        spi_csn_i,
  input  wire        spi_mosi_i,
  input  wire        spi_sclk_i,
  input  wire        spi_drive_i,
  output reg         spi_miso_o,
  // Secondary serial port
  input  wire        serial_txd_i,
  output reg         serial_rxd_o,
  // Secondary two-wire unit
  input  wire        twowire_scl_out_i,
  input  wire        twowire_scl_oe_i,
  input  wire        twowire_sda_out_i,
  input  wire        twowire_sda_oe_i,
  output reg         twowire_scl_in_o,
  output reg         twowire_sda_in_o,
  // Bus transceiver path toward the supply companion chip
  input  wire        bus_mod_txd_i,
  output reg         bus_mod_rxd_o,
  output reg         companion_txd_o,
  input  wire        companion_rxd_i
);

  // ----------------------------------------
  // Owner codes
  // ----------------------------------------
  localparam [4:0] OWN_GPIO  = 5'h01;
  localparam [4:0] OWN_SPI   = 5'h02;
  localparam [4:0] OWN_USART = 5'h04;
  localparam [4:0] OWN_I2C   = 5'h08;
  localparam [4:0] OWN_LIN   = 5'h10;

  // ----------------------------------------
  // Configuration held in flip-flops
  // ----------------------------------------
  // Captured every cycle so reset alone forces the default pad state
  reg [15:0] drv_type;
  reg [1:0]  spi_cfg;
  reg [2:0]  usart_cfg;
  reg [2:0]  i2c_cfg;
  reg        lin_test;

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      drv_type  <= `DRV_TYPE_RST;
      spi_cfg   <= `SPI_CFG_RST;
      usart_cfg <= `USART_CFG_RST;
      i2c_cfg   <= `I2C_CFG_RST;
      lin_test  <= `LIN_TEST_RST;
    end else begin
      drv_type  <= pad_driver_type_i;
      spi_cfg   <= spi_route_cfg_i;
      usart_cfg <= serial_port_route_cfg_i;
      i2c_cfg   <= twowire_route_cfg_i;
      lin_test  <= bus_phy_test_bypass_i;
    end
  end

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [16:0] sync_all;
  wire [15:0] pad_s;
  wire        comp_rxd_s;

  pad_sync2 #(
    .WIDTH (17)
  ) u_sync (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .async_i ({companion_rxd_i, pad_in_i}),
    .sync_o  (sync_all)
  );

  assign pad_s      = sync_all[15:0];
  assign comp_rxd_s = sync_all[16];

  // ----------------------------------------
  // Pad positions of the selected sets
  // ----------------------------------------
  wire       spi_en   = spi_cfg[`ROUTE_EN_BIT];
  wire       usart_en = usart_cfg[`ROUTE_EN_BIT];
  wire       i2c_en   = i2c_cfg[`ROUTE_EN_BIT];
  wire [3:0] spi_base = spi_cfg[`SPI_SET_BIT] ? `SPI_SET1_BASE : `SPI_SET0_BASE;
  wire [3:0] csn_pad  = spi_base;
  wire [3:0] mosi_pad = spi_base + 4'h1;
  wire [3:0] miso_pad = spi_base + 4'h2;
  wire [3:0] sclk_pad = spi_base + 4'h3;
  reg  [3:0] utx_pad;
  reg  [3:0] urx_pad;
  reg  [3:0] scl_pad;
  reg  [3:0] sda_pad;

  always @* begin
    case (usart_cfg[`ROUTE_SET_HI:`ROUTE_SET_LO])
      2'h0: begin
        utx_pad = `USART_TX_SET0;
        urx_pad = `USART_RX_SET0;
      end
      2'h1: begin
        utx_pad = `USART_TX_SET1;
        urx_pad = `USART_RX_SET1;
      end
      2'h2: begin
        utx_pad = `USART_TX_SET2;
        urx_pad = `USART_RX_SET2;
      end
      default: begin
        utx_pad = `USART_TX_SET3;
        urx_pad = `USART_RX_SET3;
      end
    endcase
  end

  always @* begin
    case (i2c_cfg[`ROUTE_SET_HI:`ROUTE_SET_LO])
      2'h0: begin
        scl_pad = `I2C_SCL_SET0;
        sda_pad = `I2C_SDA_SET0;
      end
      2'h1: begin
        scl_pad = `I2C_SCL_SET1;
        sda_pad = `I2C_SDA_SET1;
      end
      2'h2: begin
        scl_pad = `I2C_SCL_SET2;
        sda_pad = `I2C_SDA_SET2;
      end
      default: begin
        scl_pad = `I2C_SCL_SET3;
        sda_pad = `I2C_SDA_SET3;
      end
    endcase
  end

  // ----------------------------------------
  // Per-pad ownership and drive
  // ----------------------------------------
  // Winner masks tell each peripheral which pad it really holds
  wire [15:0] win_miso;
  wire [15:0] win_urx;
  wire [15:0] win_scl;
  wire [15:0] win_sda;
  wire [15:0] win_lin_tx;
  wire [15:0] win_gpio;

  genvar p;
  generate
    for (p = 0; p < `PAD_COUNT; p = p + 1) begin : g_pad
      localparam [3:0] PIDX = p;
      wire hit_lin_tx = lin_test && (PIDX == `LIN_TX_PAD);
      wire hit_lin_rx = lin_test && (PIDX == `LIN_RX_PAD);
      wire hit_scl    = i2c_en && (PIDX == scl_pad);
      wire hit_sda    = i2c_en && (PIDX == sda_pad);
      wire hit_utx    = usart_en && (PIDX == utx_pad);
      wire hit_urx    = usart_en && (PIDX == urx_pad);
      wire hit_csn    = spi_en && (PIDX == csn_pad);
      wire hit_mosi   = spi_en && (PIDX == mosi_pad);
      wire hit_miso   = spi_en && (PIDX == miso_pad);
      wire hit_sclk   = spi_en && (PIDX == sclk_pad);
      wire push_pull  = drv_type[p];
      reg  [4:0] owner;
      reg        value;
      reg        drive;
      reg        odrain;

      always @* begin
        if (hit_lin_tx || hit_lin_rx)
          owner = OWN_LIN;
        else if (hit_scl || hit_sda)
          owner = OWN_I2C;
        else if (hit_utx || hit_urx)
          owner = OWN_USART;
        else if (hit_csn || hit_mosi || hit_miso || hit_sclk)
          owner = OWN_SPI;
        else
          owner = OWN_GPIO;
      end

      always @* begin
        value  = `LINE_IDLE;
        drive  = 1'b0;
        odrain = ~push_pull;
        case (owner)
          OWN_LIN: begin
            // Pad 4 only listens; pad 2 mirrors the companion receive line
            value = comp_rxd_s;
            drive = hit_lin_rx;
          end
          OWN_I2C: begin
            value  = hit_scl ? twowire_scl_out_i : twowire_sda_out_i;
            drive  = hit_scl ? twowire_scl_oe_i : twowire_sda_oe_i;
            odrain = 1'b1;
          end
          OWN_USART: begin
            value  = serial_txd_i;
            drive  = hit_utx;
            odrain = hit_urx | ~push_pull;
          end
          OWN_SPI: begin
            value = hit_csn ? spi_csn_i : (hit_mosi ? spi_mosi_i : spi_sclk_i);
            drive = spi_drive_i & ~hit_miso;
          end
          OWN_GPIO: begin
            value = gpio_out_i[p];
            drive = gpio_oe_i[p];
          end
          default: begin
            value = `LINE_IDLE;
            drive = 1'b0;
          end
        endcase
      end

      assign win_miso[p]   = (owner == OWN_SPI) & hit_miso;
      assign win_urx[p]    = (owner == OWN_USART) & hit_urx;
      assign win_scl[p]    = (owner == OWN_I2C) & hit_scl;
      assign win_sda[p]    = (owner == OWN_I2C) & hit_sda;
      assign win_lin_tx[p] = (owner == OWN_LIN) & hit_lin_tx;
      assign win_gpio[p]   = (owner == OWN_GPIO);

      pad_drive_cell u_cell (
        .clk_i        (clk_i),
        .rstn_i       (rstn_i),
        .value_i      (value),
        .drive_i      (drive),
        .open_drain_i (odrain),
        .pad_out_o    (pad_out_o[p]),
        .pad_oe_o     (pad_oe_o[p])
      );
    end
  endgenerate

  // ----------------------------------------
  // Inputs returned to the peripherals
  // ----------------------------------------
  // A peripheral without a pad sees its line idle (MISO reads low), not a foreign signal
  wire miso_v = |win_miso ? |(win_miso & pad_s) : `LINE_LOW;
  wire urx_v  = |win_urx ? |(win_urx & pad_s) : `LINE_IDLE;
  wire scl_v  = |win_scl ? |(win_scl & pad_s) : `LINE_IDLE;
  wire sda_v  = |win_sda ? |(win_sda & pad_s) : `LINE_IDLE;
  wire ltx_v  = |(win_lin_tx & pad_s);

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      gpio_in_o        <= {16{`LINE_LOW}};
      spi_miso_o       <= `LINE_LOW;
      serial_rxd_o     <= `LINE_IDLE;
      twowire_scl_in_o <= `LINE_IDLE;
      twowire_sda_in_o <= `LINE_IDLE;
      bus_mod_rxd_o    <= `LINE_IDLE;
      companion_txd_o  <= `LINE_IDLE;
    end else begin
      gpio_in_o        <= pad_s & win_gpio;
      spi_miso_o       <= miso_v;
      serial_rxd_o     <= urx_v;
      twowire_scl_in_o <= scl_v;
      twowire_sda_in_o <= sda_v;
      bus_mod_rxd_o    <= comp_rxd_s;
      companion_txd_o  <= lin_test ? ltx_v : bus_mod_txd_i;
    end
  end

endmodule

// >>> inc/pad_mux_consts.vh
`ifndef PAD_MUX_CONSTS_VH
`define PAD_MUX_CONSTS_VH

// ----------------------------------------
// Pad count and field positions
// ----------------------------------------
`define PAD_COUNT       16
`define ROUTE_EN_BIT    0
`define SPI_SET_BIT     1
`define ROUTE_SET_HI    2
`define ROUTE_SET_LO    1

// ----------------------------------------
// Reset values of the configuration fields
// ----------------------------------------
`define DRV_TYPE_RST    16'h0000
`define SPI_CFG_RST     2'h0
`define USART_CFG_RST   3'h0
`define I2C_CFG_RST     3'h0
`define LIN_TEST_RST    1'h0
`define LINE_IDLE       1'h1
`define LINE_LOW        1'h0

// ----------------------------------------
// Pad positions of each routing set
// ----------------------------------------
`define SPI_SET0_BASE   4'h0
`define SPI_SET1_BASE   4'h9
`define USART_TX_SET0   4'h4
`define USART_RX_SET0   4'h8
`define USART_TX_SET1   4'h2
`define USART_RX_SET1   4'h3
`define USART_TX_SET2   4'h6
`define USART_RX_SET2   4'h7
`define USART_TX_SET3   4'h9
`define USART_RX_SET3   4'ha
`define I2C_SCL_SET0    4'hb
`define I2C_SDA_SET0    4'hc
`define I2C_SCL_SET1    4'h0
`define I2C_SDA_SET1    4'h1
`define I2C_SCL_SET2    4'h4
`define I2C_SDA_SET2    4'h5
`define I2C_SCL_SET3    4'he
`define I2C_SDA_SET3    4'hf
`define LIN_TX_PAD      4'h4
`define LIN_RX_PAD      4'h2

`endif

// >>> hw/pad_sync2.v
`timescale 1ns/100ps
`include "pad_mux_consts.vh"

// ----------------------------------------
// Two-stage synchroniser for pin inputs
// ----------------------------------------
module pad_sync2 #(
  parameter WIDTH = 17
) (
  input  wire             clk_i,
  input  wire             rstn_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;

  // Resets to idle-high so an open-drain line reads released
  always @(posedge clk_i) begin
    if (!rstn_i) begin
      meta   <= {WIDTH{`LINE_IDLE}};
      stable <= {WIDTH{`LINE_IDLE}};
    end else begin
      meta   <= async_i;
      stable <= meta;
    end
  end

  assign sync_o = stable;

endmodule

// >>> hw/pad_drive_cell.v
`timescale 1ns/100ps
`include "pad_mux_consts.vh"

// ----------------------------------------
// Output stage of one pad
// ----------------------------------------
module pad_drive_cell (
  input  wire clk_i,
  input  wire rstn_i,
  input  wire value_i,
  input  wire drive_i,
  input  wire open_drain_i,
  output reg  pad_out_o,
  output reg  pad_oe_o
);

  always @(posedge clk_i) begin
    if (!rstn_i) begin
      pad_out_o <= `LINE_LOW;
      pad_oe_o  <= 1'b0;
    end else if (open_drain_i) begin
      // Only a low is driven; a high leaves the line to the pull-up
      pad_out_o <= `LINE_LOW;
      pad_oe_o  <= drive_i & ~value_i;
    end else begin
      pad_out_o <= value_i;
      pad_oe_o  <= drive_i;
    end
  end

endmodule

// >>> verification/pad_board_model.sv
`timescale 1ns/100ps
// --------------------------------
// Board: pull-ups and pin drivers
// --------------------------------
module pad_board_model (
  input  logic [15:0] pad_out_i,
  input  logic [15:0] pad_oe_i,
  input  logic [15:0] ext_en_i,
  input  logic [15:0] ext_val_i,
  output logic [15:0] pad_level_o
);
  // Every pad has a pull-up, so a released open-drain line reads high
  assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & (~ext_en_i | ext_val_i));
endmodule

// >>> verification/gpio_pad_function_mux_sva.sv
`timescale 1ns/100ps
module pad_mux_checker (
  input logic        clk_i,
  input logic        rstn_i,
  input logic [15:0] pad_driver_type_i,
  input logic [1:0]  spi_route_cfg_i,
  input logic [2:0]  serial_port_route_cfg_i,
  input logic [2:0]  twowire_route_cfg_i,
  input logic        bus_phy_test_bypass_i,
  input logic [15:0] pad_in_i,
  input logic [15:0] pad_out_o,
  input logic [15:0] pad_oe_o,
  input logic [15:0] gpio_out_i,
  input logic [15:0] gpio_oe_i,
  input logic [15:0] gpio_in_o,
  input logic        spi_mosi_i,
  input logic        spi_drive_i,
  input logic        serial_rxd_o,
  input logic        twowire_scl_out_i,
  input logic        twowire_scl_oe_i,
  input logic        bus_mod_txd_i,
  input logic        bus_mod_rxd_o,
  input logic        companion_txd_o,
  input logic        companion_rxd_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Edges since release, so $past never looks into reset
  logic [3:0] up;
  always @(posedge clk_i) up <= rstn_i ? {up[2:0], 1'b1} : 4'h0;

  a_reset_idle: assert property ($rose(rstn_i) |-> pad_oe_o == 16'h0 && companion_txd_o)
    else $error("pads not idle after reset");
  a_od_low_only: assert property (up[3] |-> (pad_out_o & ~$past(pad_driver_type_i, 2)) == 16'h0)
    else $error("open-drain pad drove high");
  a_gpio_drive: assert property (up[3] |-> pad_oe_o[13] == ($past(gpio_oe_i[13])
    & ($past(pad_driver_type_i[13], 2) | ~$past(gpio_out_i[13])))) else $error("pad 13 enable wrong");
  a_gpio_read: assert property (up[3] |-> gpio_in_o[13] == $past(pad_in_i[13], 3))
    else $error("pad 13 read wrong");
  a_tw_open_drain: assert property (up[3] && $past(twowire_route_cfg_i, 2) == 3'h7 |-> !pad_out_o[14]
    && pad_oe_o[14] == ($past(twowire_scl_oe_i) & ~$past(twowire_scl_out_i))) else $error("clock pad wrong");
  a_rx_input_only: assert property (up[3] && $past(serial_port_route_cfg_i, 2) == 3'h3
    |-> !pad_oe_o[3] && serial_rxd_o == $past(pad_in_i[3], 3)) else $error("receive pad wrong");
  a_mosi_push_pull: assert property (up[3] && $past(spi_route_cfg_i, 2) == 2'h1
    && $past(twowire_route_cfg_i, 2) != 3'h3 && $past(pad_driver_type_i[1], 2)
    |-> pad_oe_o[1] == $past(spi_drive_i) && pad_out_o[1] == $past(spi_mosi_i)) else $error("mosi pad wrong");
  a_bypass_tx_pad: assert property (up[3] && $past(bus_phy_test_bypass_i, 2)
    |-> !pad_oe_o[4] && companion_txd_o == $past(pad_in_i[4], 3)) else $error("bypass transmit wrong");
  a_tx_normal: assert property (up[3] && !$past(bus_phy_test_bypass_i, 2)
    |-> companion_txd_o == $past(bus_mod_txd_i)) else $error("transmit path wrong");
  a_rx_sync: assert property (up[3] |-> bus_mod_rxd_o == $past(companion_rxd_i, 3))
    else $error("companion receive wrong");
  c_bypass: cover property (up[3] && $past(bus_phy_test_bypass_i, 2));
  c_twowire: cover property (up[3] && $past(twowire_route_cfg_i, 2) == 3'h7);
  c_spi: cover property (up[3] && $past(spi_route_cfg_i, 2) == 2'h1);
endmodule

bind gpio_pad_function_mux pad_mux_checker i_pad_mux_checker (.clk_i, .rstn_i, .pad_driver_type_i,
  .spi_route_cfg_i, .serial_port_route_cfg_i, .twowire_route_cfg_i, .bus_phy_test_bypass_i, .pad_in_i,
  .pad_out_o, .pad_oe_o, .gpio_out_i, .gpio_oe_i, .gpio_in_o, .spi_mosi_i, .spi_drive_i, .serial_rxd_o,
  .twowire_scl_out_i, .twowire_scl_oe_i, .bus_mod_txd_i, .bus_mod_rxd_o, .companion_txd_o, .companion_rxd_i);

// >>> verification/gpio_pad_function_mux_tb.sv
`timescale 1ns/100ps
module gpio_pad_function_mux_tb;
  logic        clk_i, rstn_i, bypass, csn, mosi, sclk, sdrv, miso, txd, rxd;
  logic        scl_o, scl_e, sda_o, sda_e, scl_in, sda_in, mtx, mrx, ctx, crx;
  logic [1:0]  spi_cfg;
  logic [2:0]  ser_cfg, tw_cfg;
  logic [15:0] drv, lvl, pad_out, pad_oe, gp_out, gp_oe, gp_in, ext_en, ext_val;
  int          fails, check_count;
  int          tx_pad[4] = '{4, 2, 6, 9};
  int          rx_pad[4] = '{8, 3, 7, 10};
  int          scl_pad[4] = '{11, 0, 4, 14};

  gpio_pad_function_mux i_gpio_pad_function_mux (.clk_i(clk_i), .rstn_i(rstn_i), .pad_driver_type_i(drv),
    .spi_route_cfg_i(spi_cfg), .serial_port_route_cfg_i(ser_cfg), .twowire_route_cfg_i(tw_cfg),
    .bus_phy_test_bypass_i(bypass), .pad_in_i(lvl), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
    .gpio_out_i(gp_out), .gpio_oe_i(gp_oe), .gpio_in_o(gp_in), .spi_csn_i(csn), .spi_mosi_i(mosi),
    .spi_sclk_i(sclk), .spi_drive_i(sdrv), .spi_miso_o(miso), .serial_txd_i(txd), .serial_rxd_o(rxd),
    .twowire_scl_out_i(scl_o), .twowire_scl_oe_i(scl_e), .twowire_sda_out_i(sda_o),
    .twowire_sda_oe_i(sda_e), .twowire_scl_in_o(scl_in), .twowire_sda_in_o(sda_in),
    .bus_mod_txd_i(mtx), .bus_mod_rxd_o(mrx), .companion_txd_o(ctx), .companion_rxd_i(crx));
  pad_board_model i_pad_board_model (.pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .pad_level_o(lvl));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Config takes two edges, pad reads three more
  task settle;
    repeat (6) @(posedge clk_i);
    #1;
  endtask

  // Full reset hold, then every pad must sit as a released input
  task t_reset;
    rstn_i = 1'b0;
    repeat (16) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    settle;
    check(pad_oe, 16'h0);
    check(gp_in, 16'hffff);
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task t_gpio;
    drv = 16'h00ff;
    gp_oe = 16'hffff;
    gp_out = 16'haaaa;
    settle;
    check(pad_oe, 16'h55ff);
    check(pad_out, 16'h00aa);
    check(gp_in, 16'haaaa);
  endtask

  task t_spi;
    int b;
    drv = 16'hffff;
    gp_out = 16'h0;
    ext_val = 16'hffff;
    sdrv = 1'b1;
    for (int s = 0; s < 4; s++) begin
      spi_cfg = s[1:0];
      b = s[1] ? 9 : 0;
      settle;
      check(gp_in, 16'h0);
      check(pad_out & ~(16'h4 << b), s[0] ? 16'hb << b : 16'h0);
      check(pad_oe, s[0] ? ~(16'h4 << b) : 16'hffff);
      check(miso, s[0]);
    end
    spi_cfg = 2'h0;
  endtask

  task t_serial;
    gp_oe = 16'h0;
    ext_en = 16'hffff;
    for (int s = 0; s < 4; s++) begin
      ser_cfg = {s[1:0], 1'b1};
      ext_val = ~(16'h1 << rx_pad[s]);
      settle;
      check(pad_oe, 16'h1 << tx_pad[s]);
      check(pad_out, 16'h1 << tx_pad[s]);
      check(gp_in, ext_val & ~(16'h1 << tx_pad[s]));
      check(rxd, 1'b0);
    end
    ser_cfg = 3'h0;
  endtask

  task t_twowire;
    ext_en = 16'h0;
    scl_o = 1'b0;
    for (int s = 0; s < 4; s++) begin
      tw_cfg = {s[1:0], 1'b1};
      settle;
      check(pad_oe, 16'h1 << scl_pad[s]);
      check(pad_out, 16'h0);
      check({scl_in, sda_in}, 2'b01);
    end
  endtask

  task t_priority;
    bypass = 1'b1;
    tw_cfg = 3'h5;
    ser_cfg = 3'h1;
    spi_cfg = 2'h1;
    sda_o = 1'b0;
    ext_en = 16'h0010;
    ext_val = 16'h0;
    crx = 1'b1;
    settle;
    check(pad_oe, 16'h002f);
    check(pad_out, 16'h001f);
    check({ctx, mrx}, 2'b01);
    bypass = 1'b0;
    settle;
    check(pad_oe, 16'h003b);
    check(pad_out, 16'h000f);
    check(ctx, 1'b1);
  endtask

  initial begin
    fails = 0;
    check_count = 0;
    {drv, gp_out, gp_oe, ext_en, ext_val} = '0;
    {spi_cfg, ser_cfg, tw_cfg, bypass, crx} = '0;
    {csn, mosi, sclk, sdrv, txd, scl_o, scl_e, sda_o, sda_e, mtx} = 10'h3bf;
    t_reset;
    t_gpio;
    t_spi;
    t_serial;
    t_twowire;
    t_priority;
    complete_run;
  end
endmodule
